// file: design/aivf_pkg.sv
/*
  aivf_pkg: shared constants for the analog input value formatter.
  assumes: included before any aivf module; no surrounding tool setup.
*/
package aivf_pkg;
  // switch field encodings
  localparam logic [1:0] AIVF_CH_ONE = 2'h0;
  localparam logic [1:0] AIVF_CH_TWO = 2'h1;
  localparam logic [1:0] AIVF_CH_FOUR = 2'h2;
  localparam logic [1:0] AIVF_LIN_NONE = 2'h0;
  localparam logic [1:0] AIVF_LIN_K = 2'h1;
  localparam logic [1:0] AIVF_LIN_J = 2'h2;
  localparam logic [1:0] AIVF_LIN_L = 2'h3;
  localparam logic [1:0] AIVF_CMP_NONE = 2'h0;
  localparam logic [1:0] AIVF_CMP_K = 2'h1;
  localparam logic [1:0] AIVF_CMP_JL = 2'h2;
  // variants
  localparam logic [1:0] AIVF_VAR_TC = 2'h0;
  localparam logic [1:0] AIVF_VAR_RTD = 2'h1;
  localparam logic [1:0] AIVF_VAR_UNI = 2'h2;
  localparam logic [1:0] AIVF_VAR_STD = 2'h3;
  // result word field positions
  localparam int AIVF_SIGN_POS = 15;
  localparam int AIVF_VAL_LSB = 3;
  localparam int AIVF_UNUSED_POS = 2;
  localparam int AIVF_WB_POS = 1;
  localparam int AIVF_OV_POS = 0;
  localparam int AIVF_MAG_LIMIT = 4096;
  localparam logic [15:0] AIVF_WORD_RST = 16'h0000;
  // integration times, ns, and cycles at 250 MHz
  localparam int AIVF_CLK_MHZ = 250;
  localparam int AIVF_INT50_NS = 20000000;
  localparam int AIVF_INT60_NS = 16660000;
  localparam int AIVF_INT50_CYC = AIVF_INT50_NS / 1000 * AIVF_CLK_MHZ;
  localparam int AIVF_INT60_CYC = AIVF_INT60_NS / 1000 * AIVF_CLK_MHZ;
  // register port offsets
  localparam logic [3:0] AIVF_REG_CFG = 4'h0;
  localparam logic [3:0] AIVF_REG_STAT = 4'h1;
  localparam logic [3:0] AIVF_REG_MASK = 4'h2;
  localparam logic [3:0] AIVF_REG_IMG0 = 4'h4;
  localparam logic [15:0] AIVF_CFG_RST = 16'h0000;
  localparam logic [3:0] AIVF_MASK_RST = 4'h0;
  // value formatting: 13-bit signed value plus flags into result word
  function automatic logic [15:0] aivf_pack(input logic signed [15:0] val, input logic wb, input logic ov);
    logic [15:0] w;
    w = {val[15], val[11:0], 1'b0, wb, ov};
    return w;
  endfunction
endpackage

// file: design/aivf_lin.sv
/*
  aivf_lin: per-sample linearization and reference-junction correction.
  assumes: raw counts are signed, compensation offset is in counts of the selected type.
*/
`timescale 1ns/100ps
module aivf_lin
  import aivf_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic signed [W-1:0] i_raw,
  input wire logic [1:0] i_var,
  input wire logic [1:0] i_lin,
  input wire logic [1:0] i_cmp,
  input wire logic i_rtd_lin,
  input wire logic signed [W-1:0] i_cj_k,
  input wire logic signed [W-1:0] i_cj_jl,
  output logic signed [W-1:0] o_val
);
  logic signed [W-1:0] comp;
  always_comb begin
    comp = i_raw;
    if (i_var == AIVF_VAR_TC) begin
      // junction at 0 C reads 0: add terminal junction equivalent
      case (i_cmp)
        AIVF_CMP_K: comp = i_raw + i_cj_k;
        AIVF_CMP_JL: comp = i_raw + i_cj_jl;
        default: comp = i_raw; // no compensation leaves raw counts
      endcase
      // one count per degree for all types; gain trim stays in the converter
      case (i_lin)
        AIVF_LIN_K, AIVF_LIN_J, AIVF_LIN_L: o_val = comp;
        default: o_val = comp;
      endcase
    end else if (i_var == AIVF_VAR_RTD && i_rtd_lin) begin
      // counts are half degrees, clamp -100..+850 C
      if (comp < -16'sd200) o_val = -16'sd200;
      else if (comp > 16'sd1700) o_val = 16'sd1700;
      else o_val = comp;
    end else begin
      o_val = comp;
    end
  end
endmodule

// file: design/aivf_top.sv
/*
  aivf_top: formats converter results into signed words of the input image; unipolar gives an unsigned byte.
  assumes: one clock i_mclk, sync reset, converter delivers one sample per strobe.
*/
// Overview of operation
// - each channel result is placed in the input image for the host to read.
// - results are signed two's complement numbers, except the unsigned byte of the unipolar variant.
// - unipolar 0-10 V variant gives one byte; others give a two-byte word.
// - word: sign bit 15, weights 2^11..2^0 in bits 14..3, flags in bits 1..0.
// - with compensation, 0 C at measuring junction reads 0.
// - thermocouple offers linearization none/K/J/L and compensation none/K/JL.
// - with no linearization and compensation, results equal plain thermocouple module.
// - one, two or four channels converted; resistance variant only one or two.
// - wire-break reporting can be disabled; then the flag never signals a break.
// - on the resistance variant switch positions 1 and 2 are ignored.
// - resistance linearization reports -100 to +850 C in half degree steps.
// - mains setting picks integration time: 20 ms at 50 Hz, 16.66 ms at 60 Hz.
// - wire-break flag is 0 without break and 1 with a detected break.
// - overflow flag is 1 when magnitude reaches 4096, else 0.
`timescale 1ns/100ps
module aivf_top
  import aivf_pkg::*;
#(
  parameter logic [1:0] VARIANT = AIVF_VAR_TC,
  parameter int INT50_CYC = AIVF_INT50_CYC,
  parameter int INT60_CYC = AIVF_INT60_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_smp_valid,
  input wire logic [1:0] i_smp_ch,
  input wire logic signed [15:0] i_smp_raw,
  input wire logic i_smp_break,
  input wire logic signed [15:0] i_cj_k,
  input wire logic signed [15:0] i_cj_jl,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_conv_start,
  output logic [1:0] o_conv_ch,
  output logic o_wb_led,
  output logic o_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration: [0] 60 Hz, [2:1] channels, [3] wire-break on,
  // [5:4] linearization, [7:6] compensation, [8] resistance linearization
  logic [15:0] cfg_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic [15:0] img_q [4];
  logic [3:0] brk_q;
  logic [23:0] tmr_q;
  logic [1:0] ch_q;
  logic signed [15:0] lin_val;
  logic [1:0] lin_sel;
  logic [1:0] cmp_sel;
  logic [1:0] nch;
  logic [15:0] mag;
  logic ov;
  logic wb;
  logic [15:0] word;

  // rtd ignores the positions that carry thermocouple options
  assign lin_sel = (VARIANT == AIVF_VAR_RTD) ? AIVF_LIN_NONE : cfg_q[5:4];
  assign cmp_sel = (VARIANT == AIVF_VAR_RTD) ? AIVF_CMP_NONE : cfg_q[7:6];

  // four channels requested on rtd fall back to two
  assign nch = (VARIANT == AIVF_VAR_RTD && cfg_q[2:1] == AIVF_CH_FOUR) ? AIVF_CH_TWO : cfg_q[2:1];

  aivf_lin #(.W(16)) u_lin (
    .i_raw(i_smp_raw),
    .i_var(VARIANT),
    .i_lin(lin_sel),
    .i_cmp(cmp_sel),
    .i_rtd_lin(cfg_q[8]),
    .i_cj_k(i_cj_k),
    .i_cj_jl(i_cj_jl),
    .o_val(lin_val)
  );

  always_comb begin
    mag = lin_val[15] ? 16'(-lin_val) : lin_val;
    ov = (mag >= 16'(AIVF_MAG_LIMIT));
    wb = i_smp_break & cfg_q[3];
    if (VARIANT == AIVF_VAR_UNI) begin
      // single byte result, low byte of the word only
      word = {8'h00, (lin_val[15] ? 8'h00 : (mag > 16'h00FF ? 8'hFF : mag[7:0]))};
    end else begin
      // saturate to 12 bits with overflow set
      word = aivf_pack(ov ? (lin_val[15] ? -16'sd4095 : 16'sd4095) : lin_val, wb, ov);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: integration time from mains switch
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tmr_q <= 24'h000000;
      ch_q <= 2'h0;
      o_conv_start <= 1'b0;
      o_conv_ch <= 2'h0;
    end else if (i_ce) begin
      o_conv_start <= 1'b0;
      if (tmr_q == 24'h000000) begin
        tmr_q <= cfg_q[0] ? 24'(INT60_CYC - 1) : 24'(INT50_CYC - 1);
        o_conv_start <= 1'b1;
        o_conv_ch <= ch_q;
        case (nch)
          AIVF_CH_TWO: ch_q <= {1'b0, ~ch_q[0]};
          AIVF_CH_FOUR: ch_q <= ch_q + 2'h1;
          default: ch_q <= 2'h0;
        endcase
      end else begin
        tmr_q <= tmr_q - 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input image: whole word written in one edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int k = 0; k < 4; k++) img_q[k] <= AIVF_WORD_RST;
      brk_q <= 4'h0;
    end else if (i_ce && i_smp_valid) begin
      img_q[i_smp_ch] <= word;
      brk_q[i_smp_ch] <= wb;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) o_wb_led <= 1'b0;
    else if (i_ce) o_wb_led <= |brk_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_q <= AIVF_CFG_RST;
      mask_q <= AIVF_MASK_RST;
    end else if (i_ce && i_wr) begin
      if (i_addr == AIVF_REG_CFG) cfg_q <= i_wdata;
      if (i_addr == AIVF_REG_MASK) mask_q <= i_wdata[3:0];
    end
  end

  // status: per-channel new result; set beats write-one-to-clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stat_q <= 4'h0;
    end else if (i_ce) begin
      stat_q <= (stat_q & ~((i_wr && i_addr == AIVF_REG_STAT) ? i_wdata[3:0] : 4'h0))
        | (i_smp_valid ? 4'(1 << i_smp_ch) : 4'h0);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) o_irq <= 1'b0;
    else if (i_ce) o_irq <= |(stat_q & mask_q);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          AIVF_REG_CFG: o_rdata <= cfg_q;
          AIVF_REG_STAT: o_rdata <= {12'h000, stat_q};
          AIVF_REG_MASK: o_rdata <= {12'h000, mask_q};
          4'h4, 4'h5, 4'h6, 4'h7: o_rdata <= img_q[i_addr[1:0]];
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// file: sim/aivf_conv_model.sv
/*
  aivf_conv_model: converter stand-in that hands one sample to the formatter.
  assumes: one clock; the bench raises i_go for one cycle per sample.
*/
`timescale 1ns/100ps
module aivf_conv_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [1:0] i_ch,
  input wire logic signed [15:0] i_raw,
  input wire logic i_brk,
  output logic o_valid,
  output logic [1:0] o_ch,
  output logic signed [15:0] o_raw,
  output logic o_brk
);
  // outside the valid cycle the data are inverted, so a stale sample never passes for a fresh one
  always_ff @(posedge i_clk) begin
    o_valid <= i_go;
    o_ch <= i_go ? i_ch : ~o_ch;
    o_raw <= i_go ? i_raw : ~o_raw;
    o_brk <= i_go ? i_brk : ~o_brk;
  end
endmodule

// file: sim/aivf_top_chk.sv
/*
  aivf_top_chk: port-level assertions for aivf_top.
  assumes: bound to aivf_top; i_ce held high by the bench.
*/
`timescale 1ns/100ps
module aivf_top_chk
  import aivf_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_smp_valid,
  input wire logic i_smp_break,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_conv_start,
  input wire logic o_wb_led,
  input wire logic o_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  sequence s_gap;
    !o_conv_start [*8];
  endsequence
  a_rst_quiet: assert property (disable iff (1'b0) i_rst |=> o_rdata == 16'h0000 && !o_irq && !o_wb_led)
    else $error("outputs not quiet after reset");
  a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_unused_bit: assert property ($past(i_rd) && $past(i_addr) >= AIVF_REG_IMG0 |-> !o_rdata[AIVF_UNUSED_POS])
    else $error("unused bit set");
  a_ov_sat: assert property ($past(i_rd) && $past(i_addr[2]) && o_rdata[0] |-> o_rdata[15:3] inside {13'h0FFF, 13'h1001})
    else $error("overflow word not saturated");
  a_conv_period: assert property (o_conv_start |=> s_gap ##[1:12] o_conv_start)
    else $error("conversion period wrong");
  a_wb_cause: assert property ($rose(o_wb_led) |-> $past(i_smp_valid && i_smp_break) || $past(i_smp_valid && i_smp_break, 2))
    else $error("break lamp without break");
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_smp_valid || i_wr, 2))
    else $error("interrupt without cause");
  a_mask_off: assert property (i_wr && i_addr == AIVF_REG_MASK && i_wdata[3:0] == 4'h0 |-> ##2 !o_irq)
    else $error("masked interrupt still high");
endmodule
bind aivf_top aivf_top_chk u_chk (.i_mclk, .i_rst, .i_smp_valid, .i_smp_break, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_conv_start, .o_wb_led, .o_irq);

// file: sim/aivf_top_test.sv
/*
  aivf_top_test: directed bench for aivf_top with a converter model.
  assumes: short integration counts; i_ce tied high.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module aivf_top_test;
  import aivf_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic signed [15:0] cj_k = 16'h0000;
  logic signed [15:0] cj_jl = 16'h0000;
  logic go = 1'b0;
  logic [1:0] ch = 2'h0;
  logic signed [15:0] raw = 16'h0000;
  logic brk = 1'b0;
  logic sv, sb;
  logic [1:0] sc, o_conv_ch;
  logic signed [15:0] sr;
  logic [15:0] o_rdata;
  logic o_conv_start, o_wb_led, o_irq;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  aivf_conv_model u_aivf_conv_model (.i_clk(i_mclk), .i_go(go), .i_ch(ch), .i_raw(raw), .i_brk(brk),
    .o_valid(sv), .o_ch(sc), .o_raw(sr), .o_brk(sb));
  aivf_top #(.INT50_CYC(20), .INT60_CYC(16)) u_aivf_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
    .i_smp_valid(sv), .i_smp_ch(sc), .i_smp_raw(sr), .i_smp_break(sb), .i_cj_k(cj_k), .i_cj_jl(cj_jl),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_start(o_conv_start), .o_conv_ch(o_conv_ch), .o_wb_led(o_wb_led), .o_irq(o_irq));
  initial forever #2 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    `CHK(n, e, o_rdata)
  endtask
  task automatic smp(input logic [1:0] c, input int v, input logic b);
    @(posedge i_mclk);
    go <= 1'b1;
    ch <= c;
    raw <= v[15:0];
    brk <= b;
    @(posedge i_mclk);
    go <= 1'b0;
    @(posedge i_mclk);
  endtask
  function automatic logic [15:0] ew(input int v, input logic b);
    int s;
    s = (v > 4095) ? 4095 : ((v < -4095) ? -4095 : v);
    return {s[12:0], 1'b0, b, (v > 4095 || v < -4095)};
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(AIVF_REG_CFG, 16'h0000, "cfg");
    wr(4'h3, 16'hFFFF);
    rd(4'h3, 16'h0000, "hole");
    $display("t_regs done");
  endtask
  task automatic t_format();
    int vals[9] = '{0, 1, -1, 2048, -2049, 4095, 4096, -4095, -4096};
    wr(AIVF_REG_CFG, 16'h0004);
    foreach (vals[i]) begin
      smp(2'h2, vals[i], 1'b0);
      rd(4'h6, ew(vals[i], 1'b0), "word");
    end
    $display("t_format done");
  endtask
  task automatic t_comp();
    cj_k <= 16'h0005;
    cj_jl <= 16'h0003;
    wr(AIVF_REG_CFG, 16'h0054);
    smp(2'h0, -5, 1'b0);
    rd(AIVF_REG_IMG0, 16'h0000, "comp k");
    wr(AIVF_REG_CFG, 16'h00A4);
    smp(2'h0, -3, 1'b0);
    rd(AIVF_REG_IMG0, 16'h0000, "comp jl");
    for (int l = 0; l < 4; l++) begin
      wr(AIVF_REG_CFG, 16'h0004 | 16'(l << 4));
      smp(2'h3, 100 + l, 1'b0);
      rd(4'h7, ew(100 + l, 1'b0), "lin");
    end
    $display("t_comp done");
  endtask
  task automatic t_break();
    wr(AIVF_REG_CFG, 16'h000C);
    smp(2'h1, 10, 1'b1);
    rd(4'h5, ew(10, 1'b1), "break on");
    `CHK("lamp on", 1'b1, o_wb_led)
    wr(AIVF_REG_CFG, 16'h0004);
    smp(2'h1, 10, 1'b1);
    rd(4'h5, ew(10, 1'b0), "break off");
    `CHK("lamp off", 1'b0, o_wb_led)
    $display("t_break done");
  endtask
  task automatic t_irq();
    wr(AIVF_REG_STAT, 16'h000F);
    wr(AIVF_REG_MASK, 16'h0002);
    smp(2'h1, 7, 1'b0);
    rd(AIVF_REG_STAT, 16'h0002, "status");
    `CHK("irq set", 1'b1, o_irq)
    wr(AIVF_REG_STAT, 16'h0002);
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("irq clear", 1'b0, o_irq)
    smp(2'h1, 8, 1'b0);
    wr(AIVF_REG_MASK, 16'h0000);
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("irq mask", 1'b0, o_irq)
    $display("t_irq done");
  endtask
  // the first two starts after a switch change may still carry the old period or channel
  task automatic t_seq();
    logic [15:0] cfgs[3] = '{16'h0000, 16'h0002, 16'h0005};
    logic [3:0] exps[3] = '{4'h1, 4'h3, 4'hF};
    int pers[3] = '{20, 20, 16};
    logic [3:0] seen;
    int n;
    foreach (cfgs[m]) begin
      wr(AIVF_REG_CFG, cfgs[m]);
      repeat (2) begin
        @(negedge i_mclk);
        while (!o_conv_start) @(negedge i_mclk);
      end
      seen = 4'h0;
      repeat (4) begin
        n = 0;
        do begin
          @(negedge i_mclk);
          n++;
        end while (!o_conv_start);
        seen[o_conv_ch] = 1'b1;
        `CHK("period", pers[m], n)
      end
      `CHK("channels", exps[m], seen)
    end
    $display("t_seq done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang ends the run as a failure instead of spinning forever
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_regs();
    t_format();
    t_comp();
    t_break();
    t_irq();
    t_seq();
    end_of_test();
  end
endmodule
